// File: design/asr_baud.sv
`default_nettype none
module asr_baud #(
   parameter int PRE_W = 10
) (
   // Clock and control
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   // Source selection
   input wire logic ext_sel_i,
   input wire logic ext_tick_i,
   input wire logic [3:0] presc_i,
   input wire logic [7:0] divk_i,
   // Oversampling tick
   output logic tick_o
);
   typedef struct packed {
      logic [PRE_W-1:0] pre_cnt;
      logic [7:0] div_cnt;
      logic tick;
   } asr_baud_t;

   asr_baud_t s;
   asr_baud_t next_s;
   logic [PRE_W-1:0] pre_mask;
   logic src_tick;

   // Prescaler divides by 2^m (capped at 1024 for m of 10 and above), then the divisor counter divides by k
   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      pre_mask = PRE_W'((1 << presc_i) - 1);
      src_tick = ext_sel_i ? ext_tick_i : (s.pre_cnt >= pre_mask);
      if (src_tick || ext_sel_i) begin
         next_s.pre_cnt = '0;
      end else begin
         next_s.pre_cnt = s.pre_cnt + 1'b1;
      end
      // k of zero wraps to a divide by 256 rather than stalling
      if (src_tick) begin
         if (s.div_cnt >= 8'(divk_i - 8'h01)) begin
            next_s.div_cnt = '0;
            next_s.tick = 1'b1;
         end else begin
            next_s.div_cnt = s.div_cnt + 8'h01;
         end
      end
   end

   // Holds its count while the channel is frozen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else if (en_i) begin
         s <= next_s;
      end
   end

   assign tick_o = s.tick;
endmodule : asr_baud
`default_nettype wire

// File: design/asr_pkg.sv
`default_nettype none
package asr_pkg;
   // Register byte offsets
   localparam logic [4:0] OFS_MODE = 5'h00;
   localparam logic [4:0] OFS_STATUS = 5'h04;
   localparam logic [4:0] OFS_DIV = 5'h08;
   localparam logic [4:0] OFS_SRC = 5'h0C;
   localparam logic [4:0] OFS_TXDATA = 5'h10;
   localparam logic [4:0] OFS_RXBUF = 5'h14;
   localparam logic [4:0] OFS_STATE = 5'h18;
   // Mode register fields
   localparam int MODE_RX_ENABLE_BIT = 6;
   localparam int MODE_PAR_HI = 5;
   localparam int MODE_PAR_LO = 4;
   localparam int MODE_LEN8 = 3;
   localparam int MODE_STOP2 = 2;
   localparam int MODE_ISRM = 1;
   // Source register fields
   localparam int SRC_EXT = 4;
   localparam int SRC_PRE_HI = 3;
   // State register fields
   localparam int ST_TX_BUSY = 0;
   localparam int ST_RX_BUSY = 1;
   localparam int ST_RX_FULL = 2;
   // Error status values
   localparam logic [7:0] ERR_PARITY = 8'h04;
   localparam logic [7:0] ERR_FRAMING = 8'h02;
   localparam logic [7:0] ERR_OVERRUN = 8'h01;
   // Reset values
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] DIV_RST = 8'h00;
   localparam logic [4:0] SRC_RST = 5'h00;
   // Bit timing in baud ticks, and character lengths in bits
   localparam logic [4:0] HALF_BIT = 5'h08;
   localparam logic [4:0] LAST_TICK = 5'h0F;
   localparam logic [3:0] BITS8 = 4'h8;
   localparam logic [3:0] BITS7 = 4'h7;
   // Parity modes
   typedef enum logic [1:0] {
      PAR_NONE = 2'b00,
      PAR_ZERO = 2'b01,
      PAR_ODD = 2'b10,
      PAR_EVEN = 2'b11
   } asr_par_t;
   // Transmit and receive sequencer states
   typedef enum logic [2:0] {
      SQ_IDLE = 3'b000,
      SQ_START = 3'b001,
      SQ_DATA = 3'b010,
      SQ_PAR = 3'b011,
      SQ_STOP = 3'b100
   } asr_seq_t;
endpackage : asr_pkg
`default_nettype wire

// File: design/asr_top.sv
`default_nettype none
module asr_top #(
   parameter int ADDR_W = 8
) (
   // Clock, reset and power control
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic CE_I,
   input wire logic IDLE_STOP_I,
   // APB slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // Serial pins
   input wire logic SERIAL_IN_I,
   input wire logic EXT_BAUD_I,
   output logic SERIAL_OUT_O,
   // Interrupt request pulses
   output logic TX_DONE_IRQ_O,
   output logic RX_DONE_IRQ_O,
   output logic RX_ERR_IRQ_O
);
   typedef struct packed {
      logic [7:0] async_mode_reg;
      logic [7:0] rx_error_status_reg;
      logic [7:0] baud_divisor_reg;
      logic [4:0] baud_source_select_reg;
      logic [7:0] rx_buffer_reg;
      logic rx_full;
      asr_pkg::asr_seq_t tx_state;
      logic [4:0] tx_cnt;
      logic [3:0] tx_bit;
      logic [7:0] tx_shift_reg;
      logic tx_par;
      logic txd;
      logic tx_done_irq;
      asr_pkg::asr_seq_t rx_state;
      logic [4:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_par;
      logic done_pend;
      logic rx_done_irq;
      logic rx_error_irq;
      logic [2:0] rx_sync;
      logic rx_line;
      logic rx_prev;
      logic [2:0] ext_sync;
      logic ext_line;
      logic ext_tick;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } asr_state_t;

   asr_state_t s;
   asr_state_t next_s;
   logic run;
   logic tick;
   logic [4:0] ofs;
   logic len8;
   logic [3:0] nbits;
   asr_pkg::asr_par_t par_mode;
   logic [7:0] rx_data;
   logic [7:0] errs;

   // Parity (XOR) of the ones over the valid character bits
   function automatic logic char_parity(input logic [7:0] d,
                                        input logic l8);
      char_parity = l8 ? ^d : ^d[6:0];
   endfunction

   // Parity bit sent, or expected, for a given character
   function automatic logic par_bit(input logic [7:0] d, input logic l8,
                                    input asr_pkg::asr_par_t pm);
      case (pm)
         asr_pkg::PAR_EVEN: par_bit = char_parity(d, l8);
         asr_pkg::PAR_ODD: par_bit = ~char_parity(d, l8);
         default: par_bit = 1'b0;
      endcase
   endfunction

   // Frozen whenever CE_I is low, and in idle unless an external serial clock is used
   assign run = CE_I & ~(IDLE_STOP_I &
                ~s.baud_source_select_reg[asr_pkg::SRC_EXT]);

   asr_baud #(
      .PRE_W(10)
   ) asr_baud_i (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .en_i(run),
      .ext_sel_i(s.baud_source_select_reg[asr_pkg::SRC_EXT]),
      .ext_tick_i(s.ext_tick),
      .presc_i(s.baud_source_select_reg[asr_pkg::SRC_PRE_HI:0]),
      .divk_i(s.baud_divisor_reg),
      .tick_o(tick)
   );

   // Decoded offset and mode fields
   assign ofs = PADDR_I[4:0];
   assign len8 = s.async_mode_reg[asr_pkg::MODE_LEN8];
   assign nbits = len8 ? asr_pkg::BITS8 : asr_pkg::BITS7;
   assign par_mode = asr_pkg::asr_par_t'(
      s.async_mode_reg[asr_pkg::MODE_PAR_HI:asr_pkg::MODE_PAR_LO]);
   // Seven-bit characters arrive in the top bits of the shifter
   assign rx_data = len8 ? s.rx_sh : {1'b0, s.rx_sh[7:1]};

   always_comb begin
      next_s = s;
      next_s.tx_done_irq = 1'b0;
      next_s.rx_done_irq = 1'b0;
      next_s.rx_error_irq = 1'b0;
      next_s.ext_tick = 1'b0;
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
      errs = '0;

      // Pin synchronisers; a change counts once stages two and three agree
      next_s.rx_sync = {s.rx_sync[1:0], SERIAL_IN_I};
      if (s.rx_sync[1] == s.rx_sync[2]) begin
         next_s.rx_line = s.rx_sync[2];
      end
      next_s.rx_prev = s.rx_line;
      next_s.ext_sync = {s.ext_sync[1:0], EXT_BAUD_I};
      if (s.ext_sync[1] == s.ext_sync[2]) begin
         next_s.ext_line = s.ext_sync[2];
      end
      next_s.ext_tick = next_s.ext_line & ~s.ext_line;

      // APB access phase: one wait state, then the data phase completes
      if (PSEL_I && PENABLE_I && !s.pready) begin
         next_s.pready = 1'b1;
         next_s.pslverr = 1'b0;
         next_s.prdata = '0;
         case (ofs)
            asr_pkg::OFS_MODE: next_s.prdata[7:0] = s.async_mode_reg;
            asr_pkg::OFS_STATUS: next_s.prdata[7:0] = s.rx_error_status_reg;
            asr_pkg::OFS_DIV: next_s.prdata[7:0] = s.baud_divisor_reg;
            asr_pkg::OFS_SRC: next_s.prdata[4:0] = s.baud_source_select_reg;
            asr_pkg::OFS_TXDATA: next_s.prdata[7:0] = s.tx_shift_reg;
            asr_pkg::OFS_RXBUF: next_s.prdata[7:0] = s.rx_buffer_reg;
            asr_pkg::OFS_STATE: begin
               next_s.prdata[asr_pkg::ST_TX_BUSY] =
                  (s.tx_state != asr_pkg::SQ_IDLE);
               next_s.prdata[asr_pkg::ST_RX_BUSY] =
                  (s.rx_state != asr_pkg::SQ_IDLE);
               next_s.prdata[asr_pkg::ST_RX_FULL] = s.rx_full;
            end
            default: next_s.pslverr = 1'b1;
         endcase
         if (PADDR_I[ADDR_W-1:5] != '0) begin
            next_s.pslverr = 1'b1;
            next_s.prdata = '0;
         end
      end

      // Side effects act only on the completing edge
      if (PSEL_I && PENABLE_I && s.pready && !s.pslverr) begin
         if (PWRITE_I && PSTRB_I[0]) begin
            case (ofs)
               asr_pkg::OFS_MODE: next_s.async_mode_reg = PWDATA_I[7:0];
               asr_pkg::OFS_DIV: next_s.baud_divisor_reg = PWDATA_I[7:0];
               asr_pkg::OFS_SRC:
                  next_s.baud_source_select_reg = PWDATA_I[4:0];
               asr_pkg::OFS_TXDATA: begin
                  // Writes while a frame is on the wire are dropped
                  if (s.tx_state == asr_pkg::SQ_IDLE) begin
                     next_s.tx_shift_reg = len8 ? PWDATA_I[7:0] :
                                           {1'b0, PWDATA_I[6:0]};
                     next_s.tx_par = par_bit(PWDATA_I[7:0], len8,
                                             par_mode);
                     next_s.tx_state = asr_pkg::SQ_START;
                     next_s.tx_cnt = '0;
                     next_s.tx_bit = '0;
                     next_s.txd = 1'b0;
                  end
               end
               default: ;
            endcase
         end else if (!PWRITE_I && ofs == asr_pkg::OFS_RXBUF) begin
            next_s.rx_error_status_reg = '0;
            next_s.rx_full = 1'b0;
         end
      end

      // Transmitter: sixteen ticks per bit, LSB first
      if (s.tx_state != asr_pkg::SQ_IDLE && tick) begin
         next_s.tx_cnt = s.tx_cnt + 5'h01;
         if (s.tx_cnt == asr_pkg::LAST_TICK) begin
            next_s.tx_cnt = '0;
            case (s.tx_state)
               asr_pkg::SQ_START, asr_pkg::SQ_DATA: begin
                  if (s.tx_state == asr_pkg::SQ_DATA &&
                      s.tx_bit == nbits) begin
                     if (par_mode != asr_pkg::PAR_NONE) begin
                        next_s.txd = s.tx_par;
                        next_s.tx_state = asr_pkg::SQ_PAR;
                     end else begin
                        next_s.txd = 1'b1;
                        next_s.tx_state = asr_pkg::SQ_STOP;
                        next_s.tx_bit = '0;
                     end
                  end else begin
                     next_s.txd = s.tx_shift_reg[0];
                     next_s.tx_shift_reg = {1'b0, s.tx_shift_reg[7:1]};
                     next_s.tx_bit = s.tx_bit + 4'h1;
                     next_s.tx_state = asr_pkg::SQ_DATA;
                  end
               end
               asr_pkg::SQ_PAR: begin
                  next_s.txd = 1'b1;
                  next_s.tx_state = asr_pkg::SQ_STOP;
                  next_s.tx_bit = '0;
               end
               asr_pkg::SQ_STOP: begin
                  if (s.async_mode_reg[asr_pkg::MODE_STOP2] &&
                      s.tx_bit == 4'h0) begin
                     next_s.tx_bit = 4'h1;
                  end else begin
                     next_s.tx_state = asr_pkg::SQ_IDLE;
                     next_s.tx_done_irq = 1'b1;
                  end
               end
               default: next_s.tx_state = asr_pkg::SQ_IDLE;
            endcase
         end
      end

      // Receive-done follows the error pulse by one cycle
      if (s.done_pend) begin
         next_s.done_pend = 1'b0;
         next_s.rx_done_irq = 1'b1;
      end

      // Receiver
      if (!s.async_mode_reg[asr_pkg::MODE_RX_ENABLE_BIT]) begin
         // Abort leaves buffer and status untouched
         next_s.rx_state = asr_pkg::SQ_IDLE;
         next_s.rx_cnt = '0;
         next_s.done_pend = 1'b0;
         next_s.rx_done_irq = 1'b0;
      end else begin
         case (s.rx_state)
            asr_pkg::SQ_IDLE: begin
               // Falling line starts the half-bit count
               if (s.rx_prev && !s.rx_line) begin
                  next_s.rx_state = asr_pkg::SQ_START;
                  next_s.rx_cnt = '0;
               end
            end
            asr_pkg::SQ_START: begin
               if (tick) begin
                  next_s.rx_cnt = s.rx_cnt + 5'h01;
                  if (s.rx_cnt == asr_pkg::HALF_BIT - 5'h01) begin
                     next_s.rx_cnt = '0;
                     next_s.rx_bit = '0;
                     // A glitch shorter than half a bit is rejected
                     next_s.rx_state = s.rx_line ? asr_pkg::SQ_IDLE :
                                       asr_pkg::SQ_DATA;
                  end
               end
            end
            asr_pkg::SQ_DATA, asr_pkg::SQ_PAR, asr_pkg::SQ_STOP: begin
               if (tick) begin
                  next_s.rx_cnt = s.rx_cnt + 5'h01;
                  if (s.rx_cnt == asr_pkg::LAST_TICK) begin
                     next_s.rx_cnt = '0;
                     case (s.rx_state)
                        asr_pkg::SQ_DATA: begin
                           next_s.rx_sh = {s.rx_line, s.rx_sh[7:1]};
                           next_s.rx_bit = s.rx_bit + 4'h1;
                           if (s.rx_bit == nbits - 4'h1) begin
                              next_s.rx_state =
                                 (par_mode == asr_pkg::PAR_NONE) ?
                                 asr_pkg::SQ_STOP : asr_pkg::SQ_PAR;
                           end
                        end
                        asr_pkg::SQ_PAR: begin
                           next_s.rx_par = s.rx_line;
                           next_s.rx_state = asr_pkg::SQ_STOP;
                        end
                        default: begin
                           // One stop bit closes the frame
                           if ((par_mode == asr_pkg::PAR_EVEN ||
                                par_mode == asr_pkg::PAR_ODD) &&
                               par_bit(rx_data, len8, par_mode) != s.rx_par)
                           begin
                              errs = errs | asr_pkg::ERR_PARITY;
                           end
                           if (!s.rx_line) begin
                              errs = errs | asr_pkg::ERR_FRAMING;
                           end
                           if (next_s.rx_full) begin
                              errs = errs | asr_pkg::ERR_OVERRUN;
                           end
                           // New frame replaces status, winning over a read
                           next_s.rx_error_status_reg = errs;
                           next_s.rx_buffer_reg = rx_data;
                           next_s.rx_full = 1'b1;
                           next_s.rx_error_irq = (errs != '0);
                           next_s.done_pend = (errs == '0) ||
                              !s.async_mode_reg[asr_pkg::MODE_ISRM];
                           next_s.rx_state = asr_pkg::SQ_IDLE;
                        end
                     endcase
                  end
               end
            end
            default: next_s.rx_state = asr_pkg::SQ_IDLE;
         endcase
      end
   end

   // One register for all channel state but the baud counters, held while frozen
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         s <= '0;
         s.async_mode_reg <= asr_pkg::MODE_RST;
         s.baud_divisor_reg <= asr_pkg::DIV_RST;
         s.baud_source_select_reg <= asr_pkg::SRC_RST;
         s.txd <= 1'b1;
         s.rx_sync <= 3'h7;
         s.rx_line <= 1'b1;
         s.rx_prev <= 1'b1;
      end else if (run) begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign PRDATA_O = s.prdata;
   assign PREADY_O = s.pready;
   assign PSLVERR_O = s.pslverr;
   assign SERIAL_OUT_O = s.txd;
   assign TX_DONE_IRQ_O = s.tx_done_irq;
   assign RX_DONE_IRQ_O = s.rx_done_irq;
   assign RX_ERR_IRQ_O = s.rx_error_irq;
endmodule : asr_top
`default_nettype wire

// File: test/asr_remote.sv
`default_nettype none
module asr_remote #(
   parameter int BIT = 32
) (
   // Clock and serial lines
   input wire logic clk_i,
   input wire logic line_i,
   output logic line_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [10:0] cap;
   logic prev;
   int frames = 0;
   initial line_o = 1'b1;
   // Capture mid-bit after a falling edge; 11 samples cover start, eight data, parity and one stop bit
   always @(posedge clk_i) begin
      prev <= line_i;
      if (prev === 1'b1 && line_i === 1'b0) begin
         repeat (BIT / 2) @(posedge clk_i);
         for (int i = 0; i < 11; i++) begin
            cap[i] = line_i;
            repeat (BIT) @(posedge clk_i);
         end
         frames++;
      end
   end
   // Send n bits LSB first, then idle high for a cycle
   task automatic send(input logic [11:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         line_o <= f[i];
         repeat (BIT) @(posedge clk_i);
      end
      line_o <= 1'b1;
      @(posedge clk_i);
   endtask
   // Short low pulse, too short to pass for a start bit
   task automatic glitch(input int w);
      line_o <= 1'b0;
      repeat (w) @(posedge clk_i);
      line_o <= 1'b1;
   endtask
endmodule  // asr_remote
`default_nettype wire

// File: test/asr_top_props.sv
`default_nettype none
module asr_top_props #(
   parameter int ADDR_W = 8
) (
   // Clock, reset and power control
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic CE_I,
   input wire logic IDLE_STOP_I,
   // APB
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   // Serial side
   input wire logic SERIAL_OUT_O,
   input wire logic TX_DONE_IRQ_O,
   input wire logic RX_DONE_IRQ_O,
   input wire logic RX_ERR_IRQ_O
);
   timeunit 1ns;
   timeprecision 1ps;
   logic isrm, rx_enable_bit, len8, ext, run, acc, rd_st, rd_rb;
   // A frozen cycle changes nothing, so writes only act while running
   assign run = CE_I && !(IDLE_STOP_I && !ext);
   assign acc = PSEL_I && PENABLE_I && PREADY_O;
   assign rd_st = acc && !PWRITE_I && PADDR_I == ADDR_W'(asr_pkg::OFS_STATUS);
   assign rd_rb = acc && !PWRITE_I && PADDR_I == ADDR_W'(asr_pkg::OFS_RXBUF);
   // Shadow of the mode and source bits
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         {isrm, rx_enable_bit, len8, ext} <= 4'h0;
      end else if (acc && run && PWRITE_I && PSTRB_I[0]) begin
         if (PADDR_I == ADDR_W'(asr_pkg::OFS_MODE)) begin
            isrm <= PWDATA_I[asr_pkg::MODE_ISRM];
            rx_enable_bit <= PWDATA_I[asr_pkg::MODE_RX_ENABLE_BIT];
            len8 <= PWDATA_I[asr_pkg::MODE_LEN8];
         end
         if (PADDR_I == ADDR_W'(asr_pkg::OFS_SRC)) begin
            ext <= PWDATA_I[asr_pkg::SRC_EXT];
         end
      end
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   a_err_then_done: assert property (
      RX_ERR_IRQ_O && !isrm && rx_enable_bit && run |=> RX_DONE_IRQ_O)
      else $error("done pulse missing after error pulse");
   a_err_supp: assert property (
      RX_ERR_IRQ_O && isrm |=> !RX_DONE_IRQ_O)
      else $error("done pulse not suppressed");
   a_stop_high: assert property (
      TX_DONE_IRQ_O |-> SERIAL_OUT_O && $past(SERIAL_OUT_O, 16))
      else $error("tx done without a full stop bit");
   a_rx_off: assert property (
      !rx_enable_bit && !$past(rx_enable_bit) |-> !RX_DONE_IRQ_O && !RX_ERR_IRQ_O)
      else $error("receive pulse while receiver off");
   a_freeze_hold: assert property (
      !run |=> $stable({SERIAL_OUT_O, TX_DONE_IRQ_O, RX_DONE_IRQ_O,
                        RX_ERR_IRQ_O, PREADY_O, PRDATA_O}))
      else $error("outputs moved while frozen");
   a_apb_wait: assert property (
      PSEL_I && PENABLE_I && !PREADY_O && run |=> PREADY_O)
      else $error("apb answer late");
   a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
      else $error("slave error outside completion");
   a_unmapped_err: assert property (
      acc && PADDR_I > ADDR_W'(asr_pkg::OFS_STATE) |->
         PSLVERR_O && PRDATA_O == 32'h0)
      else $error("unmapped access not refused");
   a_status_bits: assert property (
      rd_st |-> PRDATA_O[31:3] == 29'h0)
      else $error("status has bits beyond the three flags");
   a_rx_char: assert property (
      rd_rb |-> PRDATA_O[31:8] == 24'h0 && (len8 || !PRDATA_O[7]))
      else $error("receive buffer upper bits set");
endmodule  // asr_top_props
bind asr_top asr_top_props #(.ADDR_W(ADDR_W)) asr_top_props_i (
   .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I),
   .IDLE_STOP_I(IDLE_STOP_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
   .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
   .PSLVERR_O(PSLVERR_O), .SERIAL_OUT_O(SERIAL_OUT_O),
   .TX_DONE_IRQ_O(TX_DONE_IRQ_O), .RX_DONE_IRQ_O(RX_DONE_IRQ_O),
   .RX_ERR_IRQ_O(RX_ERR_IRQ_O));
`default_nettype wire

// File: test/asr_top_tb_top.sv
`default_nettype none
module asr_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BIT = 32;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic idle = 1'b0;
   logic [1:0] ebc = 2'h0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rv;
   logic pready, pslverr, re, sin, sout, txd, rxd, rxe;
   int fails = 0;
   int cmp_count = 0;
   int n_tx = 0;
   int n_rx = 0;
   int n_er = 0;
   always #4 clk = ~clk;
   // External baud source, a rising edge every four clocks
   always @(posedge clk) ebc <= ebc + 2'h1;
   // Count one-cycle interrupt pulses
   always @(posedge clk) begin
      n_tx += int'(txd === 1'b1);
      n_rx += int'(rxd === 1'b1);
      n_er += int'(rxe === 1'b1);
   end
   asr_top asr_top_i (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce),
      .IDLE_STOP_I(idle), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .SERIAL_IN_I(sin), .EXT_BAUD_I(ebc[1]), .SERIAL_OUT_O(sout),
      .TX_DONE_IRQ_O(txd), .RX_DONE_IRQ_O(rxd), .RX_ERR_IRQ_O(rxe));
   asr_remote #(.BIT(BIT)) asr_remote_i (.clk_i(clk), .line_i(sout),
      .line_o(sin));
   task automatic summarize();
      if (fails == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e,
         input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   // One APB transfer; the request holds until pready is sampled high
   task automatic apb(input logic w, input logic [4:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      paddr <= {3'h0, a};
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
      if (n >= 100) begin
         fails++;
         summarize();
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [4:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   // Bounded wait for the partner to finish capturing k frames
   task automatic wt(input int k);
      int n;
      n = 0;
      while (asr_remote_i.frames < k && n < 1000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 1000) begin
         fails++;
         summarize();
      end
   endtask
   // Line image of a frame: start, data LSB first, parity, idle ones
   function automatic logic [11:0] frm(input logic [7:0] d, input logic l8,
         input logic [1:0] pm);
      logic [11:0] f;
      logic p;
      p = ^(d & {l8, 7'h7F});
      f = l8 ? {3'h7, d, 1'b0} : {4'hF, d[6:0], 1'b0};
      if (pm != 2'b00) begin
         f[l8 ? 9 : 8] = (pm == 2'b01) ? 1'b0 : p ^ (pm == 2'b10);
      end
      return f;
   endfunction
   task automatic t_regs();
      logic [4:0] a [6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h14, 5'h18};
      foreach (a[i]) begin
         rd(a[i]);
         chk("reset value", 32'h0, rv);
      end
      wr(5'h04, 32'hFF);
      rd(5'h04);
      chk("status read-only", 32'h0, rv);
      rd(5'h1C);
      chk("unmapped error", 32'h1, {31'h0, re});
      wr(5'h08, 32'h2);  // Two clocks a tick, so a bit is 32 clocks
      rd(5'h08);
      chk("divisor", 32'h2, rv);
   endtask
   task automatic t_tx();
      logic [11:0] f;
      for (int i = 0; i < 8; i++) begin
         wr(5'h00, {26'h0, i[1:0], i[2], 3'h0});
         f = frm(8'hA5, i[2], i[1:0]);
         wr(5'h10, 32'hA5);
         wt(i + 1);
         chk("tx frame", {21'h0, f[10:0]}, {21'h0, asr_remote_i.cap});
      end
      chk("tx done count", 32'h8, 32'(n_tx));
   endtask
   task automatic t_rx();
      logic [11:0] f;
      logic [7:0] es;
      for (int i = 0; i < 8; i++) begin
         wr(5'h00, {25'h0, 1'b1, i[1:0], 1'b1, 3'h0});
         f = frm(8'h3C ^ 8'(i), 1'b1, i[1:0]);
         if (i[2]) begin
            f[9] = ~f[9];
         end
         asr_remote_i.send(f, 10 + int'(i[1:0] != 2'b00));
         es = !i[2] ? 8'h00 : (i[1:0] == 2'b00) ? 8'h02 : {5'h0, i[1], 2'h0};
         rd(5'h04);
         chk("rx status", {24'h0, es}, rv);
         rd(5'h14);
         chk("rx data", {24'h0, 8'h3C ^ 8'(i)}, rv);
      end
      chk("rx done count", 32'h8, 32'(n_rx));
      chk("rx error count", 32'h3, 32'(n_er));
   endtask
   task automatic t_ovr();
      logic [11:0] f;
      f = frm(8'h11, 1'b1, 2'b11);
      f[9] = ~f[9];
      asr_remote_i.send(f, 11);
      asr_remote_i.send(frm(8'h22, 1'b1, 2'b11), 11);
      rd(5'h04);
      chk("overrun only", 32'h1, rv);
      rd(5'h14);
      chk("newest char", 32'h22, rv);
      rd(5'h04);
      chk("status cleared", 32'h0, rv);
   endtask
   task automatic t_isrm();
      logic [11:0] f;
      int k;
      int e;
      k = n_rx;
      e = n_er;
      wr(5'h00, 32'h7A);  // Error select on: no done pulse for bad frames
      f = frm(8'h33, 1'b1, 2'b11);
      f[9] = ~f[9];
      asr_remote_i.send(f, 11);
      chk("done suppressed", 32'(k), 32'(n_rx));
      chk("error raised", 32'(e + 1), 32'(n_er));
      rd(5'h14);
      chk("bad char kept", 32'h33, rv);
   endtask
   task automatic t_abort();
      int k;
      k = n_rx + n_er;
      fork
         asr_remote_i.send(frm(8'h44, 1'b1, 2'b11), 11);
         begin
            repeat (5 * BIT) @(posedge clk);
            wr(5'h00, 32'h38);
         end
      join
      asr_remote_i.send(frm(8'h55, 1'b1, 2'b11), 11);
      rd(5'h14);
      chk("buffer untouched", 32'h33, rv);
      chk("no pulses", 32'(k), 32'(n_rx + n_er));
   endtask
   task automatic t_glitch();
      wr(5'h00, 32'h40);  // Receiver on, 7-bit, no parity
      asr_remote_i.glitch(4);
      repeat (BIT) @(posedge clk);
      asr_remote_i.send(frm(8'hAA, 1'b0, 2'b00), 9);
      rd(5'h14);
      chk("seven-bit char", 32'h2A, rv);
   endtask
   task automatic t_freeze();
      fork
         rd(5'h08);
         begin
            ce <= 1'b0;
            repeat (10) @(posedge clk);
            ce <= 1'b1;
            idle <= 1'b1;
            repeat (10) @(posedge clk);
            idle <= 1'b0;
         end
      join
      chk("read across freeze", 32'h2, rv);
   endtask
   // An external baud source keeps the channel running in idle
   task automatic t_ext();
      int k;
      k = n_tx;
      wr(5'h0C, 32'h10);
      wr(5'h08, 32'h1);
      wr(5'h00, 32'h4);  // Two stop bits, seven-bit characters
      idle <= 1'b1;
      wr(5'h10, 32'h5A);
      repeat (800) @(posedge clk);
      idle <= 1'b0;
      chk("ext baud tx done", 32'(k + 1), 32'(n_tx));
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_tx();
      t_rx();
      t_ovr();
      t_isrm();
      t_abort();
      t_glitch();
      t_freeze();
      t_ext();
      summarize();
   end
endmodule  // asr_top_tb_top
`default_nettype wire
